/* hdl/eom_defines.svh */
// offsets, field positions, decode tables and timing counts of the option memory decoder
`ifndef EOM_DEFINES_SVH
`define EOM_DEFINES_SVH

`define EOM_MEM_BYTES 64
`define EOM_ADDR_W 6
`define EOM_OFF_SYNC_COUNTER_TX1 6'h00
`define EOM_OFF_SYNC_COUNTER_TX2 6'h08
`define EOM_OFF_SERIAL_NUMBER_TX1 6'h10
`define EOM_OFF_SEED_VALUE_TX1 6'h14
`define EOM_OFF_OPTION_CONTROL_TX1 6'h1C
`define EOM_OFF_DISCRIMINATION_LOW_TX1 6'h1D
`define EOM_OFF_CIPHER_KEY_TX1 6'h1E
`define EOM_OFF_SERIAL_NUMBER_TX2 6'h26
`define EOM_OFF_SEED_VALUE_TX2 6'h2A
`define EOM_OFF_OPTION_CONTROL_TX2 6'h32
`define EOM_OFF_DISCRIMINATION_LOW_TX2 6'h33
`define EOM_OFF_CIPHER_KEY_TX2 6'h34
`define EOM_OFF_TIMING_OPTIONS_TX1 6'h3C
`define EOM_OFF_SYSTEM_OPTIONS_A 6'h3D
`define EOM_OFF_TIMING_OPTIONS_TX2 6'h3E
`define EOM_OFF_SYSTEM_OPTIONS_B 6'h3F

// option-set control byte
`define EOM_CTL_PULSE 7
`define EOM_CTL_QUEUE 6
`define EOM_CTL_LONG_SERIAL 5
`define EOM_CTL_HEADER 4
`define EOM_CTL_MOD_LSB 2
`define EOM_CTL_DISC_LSB 0
// timing byte
`define EOM_TIM_GUARD_LSB 6
`define EOM_TIM_ELEM_LSB 4
`define EOM_TIM_SEED_DELAY_LSB 2
`define EOM_TIM_SEED_MODE 1
`define EOM_TIM_SEED_LIMIT 0
// system bytes
`define EOM_SYS_ON_TIME 7
`define EOM_SYS_BLINK 6
`define EOM_SYSA_TIMEOUT_LSB 4
`define EOM_SYSA_RADIO_OUT 3
`define EOM_SYSA_DUAL 2
`define EOM_SYSA_MIN_WORDS_LSB 0
`define EOM_SYSB_FSK 5
`define EOM_SYSB_LOWBATT_SEL 4
`define EOM_SYSB_LOWBATT_LATCH 3
`define EOM_SYSB_COUNTER_SEL 2
`define EOM_SYSB_WAKE_LSB 0

// decode tables, entry 3 first
`define EOM_ELEM_US_TABLE {10'd800, 10'd400, 10'd200, 10'd100}
`define EOM_GUARD_X100US_TABLE {11'd1024, 11'd512, 11'd64, 11'd0}
`define EOM_SEED_DELAY_MS_TABLE {12'd3200, 12'd1600, 12'd800, 12'd0}
`define EOM_TIMEOUT_X100MS_TABLE {9'd256, 9'd32, 9'd8, 9'd0}
`define EOM_MIN_WORDS_TABLE {4'd8, 4'd4, 4'd2, 4'd1}
`define EOM_WAKE_MS_TABLE {7'd100, 7'd50, 7'd75, 7'd0}
`define EOM_WAKE_PERMILLE_TABLE {10'd166, 10'd333, 10'd500, 10'd0}
`define EOM_HEADER_SHORT_ELEM 4'd4
`define EOM_HEADER_LONG_ELEM 4'd10
`define EOM_SERIAL_SHORT_BITS 6'd28
`define EOM_SERIAL_LONG_BITS 6'd32
`define EOM_COUNTER_SHORT_BITS 5'd16
`define EOM_COUNTER_LONG_BITS 5'd20
`define EOM_LOWBATT_LOW_MV 12'd2200
`define EOM_LOWBATT_HIGH_MV 12'd3200
`define EOM_ON_TIME_SHORT_MS 7'd50
`define EOM_ON_TIME_LONG_MS 7'd100

// timing
`define EOM_REF_PERIOD_NS 10
`define EOM_LINK_GAP_NS 1000
`define EOM_LINK_GAP_CYC ((`EOM_LINK_GAP_NS + `EOM_REF_PERIOD_NS - 1) / `EOM_REF_PERIOD_NS)
`define EOM_LOAD_BYTES 8

`endif

/* hdl/eom_pkg.sv */
// types of the option memory decoder
package eom_pkg;

  typedef enum logic [1:0] {EOM_MOD_PULSE_WIDTH, EOM_MOD_MANCHESTER, EOM_MOD_VAR_PULSE_WIDTH,
    EOM_MOD_PULSE_POSITION} eom_mod_t;

  typedef enum logic [1:0] {EOM_IDLE, EOM_LOAD, EOM_DECODE} eom_load_t;

  typedef struct packed {
    logic activeSetB;
    eom_mod_t modulation;
    logic [9:0] elementTimeUs;
    logic [10:0] guardTimeX100us;
    logic [3:0] headerElements;
    logic [5:0] serialBits;
    logic [11:0] seedDelayMs;
    logic seedProduction;
    logic seedLimited;
    logic pulseFrames;
    logic queueEnable;
    logic [9:0] discrimination;
    logic [4:0] counterBits;
    logic [3:0] minWords;
    logic [8:0] timeoutX100ms;
    logic [6:0] wakePeriodMs;
    logic [9:0] wakeDutyPermille;
    logic [11:0] lowbattMv;
    logic lowbattLatch;
    logic blinkOnce;
    logic [6:0] indicatorOnMs;
    logic radioEnableOutput;
    logic radioFsk;
  } eom_opt_t;

  typedef struct packed {
    logic isRead;
    logic [5:0] addr;
    logic [7:0] wrData;
  } eom_link_req_t;

  typedef struct packed {
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic inData;
    eom_link_req_t req;
    logic cmdTgl;
    logic wrTgl;
    logic dataOut;
    logic dataOe;
  } eom_link_st_t;

endpackage : eom_pkg

/* hdl/eom_sync3.sv */
// three-flop synchroniser; a change is taken once the second and third flops agree
module eom_sync3 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } eom_sync_st_t;

  eom_sync_st_t st_r;
  eom_sync_st_t st_nxt;

  if (W < 1)
  begin : g_chk
    $error("eom_sync3 needs W of at least 1");
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule : eom_sync3

/* hdl/eom_link.sv */
// serial programming link slave: command byte then data byte, on the programmer's clock
module eom_link
  import eom_pkg::*;
(
  input wire logic progClk,
  input wire logic arst_n,
  input wire logic progDataIn,
  input wire logic [7:0] rdData,
  output eom_link_req_t linkReq,
  output logic cmdTgl,
  output logic wrTgl,
  output logic progDataOut,
  output logic progDataOe
);
  `include "eom_defines.svh"

  eom_link_st_t st_r;
  eom_link_st_t st_nxt;
  logic [7:0] fullByte;

  always_comb
  begin
    st_nxt = st_r;
    fullByte = {st_r.shift[6:0], progDataIn};
    st_nxt.bitCnt = st_r.bitCnt + 4'h1;
    if (!st_r.inData)
    begin
      // the bus is released at the first edge of the next command
      st_nxt.dataOe = 1'b0;
      st_nxt.shift = fullByte;
      if (st_r.bitCnt == 4'h7)
      begin
        st_nxt.req.isRead = fullByte[7];
        st_nxt.req.addr = fullByte[5:0];
        st_nxt.cmdTgl = ~st_r.cmdTgl;
        st_nxt.inData = 1'b1;
        st_nxt.bitCnt = 4'h0;
      end
    end
    else
    begin
      if (st_r.req.isRead)
      begin
        // rdData was fetched by the core during the command-to-data gap
        st_nxt.dataOut = rdData[3'h7 - st_r.bitCnt[2:0]];
        st_nxt.dataOe = 1'b1;
      end
      else
      begin
        st_nxt.shift = fullByte;
      end
      if (st_r.bitCnt == 4'h7)
      begin
        st_nxt.inData = 1'b0;
        st_nxt.bitCnt = 4'h0;
        if (!st_r.req.isRead)
        begin
          st_nxt.req.wrData = fullByte;
          st_nxt.wrTgl = ~st_r.wrTgl;
        end
      end
    end
  end

  always_ff @(posedge progClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign linkReq = st_r.req;
  assign cmdTgl = st_r.cmdTgl;
  assign wrTgl = st_r.wrTgl;
  assign progDataOut = st_r.dataOut;
  assign progDataOe = st_r.dataOe;
endmodule : eom_link

/* hdl/eom_option_decoder.sv */
// option memory: serial programming access and decode of the option bytes into parameters

// Notes on behaviour
// - two option sets; the second is used only when the dual enable bit is set.
// - modulation field: pulse-width, Manchester, variable pulse-width, pulse-position.
// - element-time field decodes to 100, 200, 400 or 800 microseconds.
// - guard-time field decodes to 0, 6.4, 51.2 or 102.4 milliseconds.
// - header lasts 4 element times, or 10 when the header bit is set.
// - serial number is 28 bits, or 32 bits when the long bit is set.
// - seed delay of 0, 0.8, 1.6 or 3.2 seconds.
// - seed mode bit picks user or production; limit bit restricts seed sending.
// - start/stop pulses only when the pulse enable bit is set.
// - queue counter only when the queue enable bit is set.
// - ten-bit discrimination from two control bits and the following byte.
// - synchronisation counter is 16 bits, or 20 bits when selected.
// - at least 1, 2, 4 or 8 code words per activation.
// - time-out of none, 0.8, 3.2 or 25.6 seconds.
// - wake-up none, 75 ms 50%, 50 ms 33.3%, 100 ms 16.6%.
// - low-voltage trip at 2.2 V or 3.2 V.
// - low-voltage indication latched only when latch enable is set.
// - low-voltage blink continuous when clear, once when set.
// - indicator on-time 50 ms when clear, 100 ms when set.
// - radio-enable output only when selected; ASK or FSK interface select.
module eom_option_decoder
  import eom_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic progClk,
  input wire logic progDataIn,
  output logic progDataOut,
  output logic progDataOe,
  input wire logic txStart,
  input wire logic txSelectB,
  output logic optBusy,
  output logic optValid,
  output logic optLoaded,
  output eom_opt_t opts
);
  `include "eom_defines.svh"

  localparam int GAP_CYC = `EOM_LINK_GAP_CYC;

  typedef struct packed {
    logic [`EOM_MEM_BYTES-1:0][7:0] mem;
    logic [`EOM_LOAD_BYTES-1:0][7:0] shadow;
    logic [2:0] loadIdx;
    eom_load_t fsm;
    logic busy;
    logic selB;
    logic [1:0] tglSeen;
    logic [7:0] rdData;
    logic optValid;
    logic optLoaded;
    eom_opt_t opts;
  } eom_core_st_t;

  eom_core_st_t st_r;
  eom_core_st_t st_nxt;
  eom_link_req_t linkReq;
  logic cmdTgl;
  logic wrTgl;
  logic [1:0] tglSync;

  // shadow slot to memory offset; slots 0..2 set A, 3..5 set B, 6..7 system
  function automatic logic [5:0] loadAddr(input logic [2:0] idx);
    logic [5:0] a;
    a = `EOM_OFF_OPTION_CONTROL_TX1;
    unique case (idx)
      3'h0: a = `EOM_OFF_OPTION_CONTROL_TX1;
      3'h1: a = `EOM_OFF_DISCRIMINATION_LOW_TX1;
      3'h2: a = `EOM_OFF_TIMING_OPTIONS_TX1;
      3'h3: a = `EOM_OFF_OPTION_CONTROL_TX2;
      3'h4: a = `EOM_OFF_DISCRIMINATION_LOW_TX2;
      3'h5: a = `EOM_OFF_TIMING_OPTIONS_TX2;
      3'h6: a = `EOM_OFF_SYSTEM_OPTIONS_A;
      3'h7: a = `EOM_OFF_SYSTEM_OPTIONS_B;
    endcase
    return a;
  endfunction : loadAddr

  function automatic eom_opt_t decodeOpts(input logic [`EOM_LOAD_BYTES-1:0][7:0] sh, input logic wantB);
    eom_opt_t o;
    logic useB;
    logic [7:0] ctl;
    logic [7:0] disc;
    logic [7:0] tim;
    logic [7:0] perSet;
    logic [7:0] sysA;
    logic [7:0] sysB;
    logic [3:0][9:0] elemTab;
    logic [3:0][10:0] guardTab;
    logic [3:0][11:0] seedTab;
    logic [3:0][8:0] toutTab;
    logic [3:0][3:0] wordTab;
    logic [3:0][6:0] wakeTab;
    logic [3:0][9:0] dutyTab;
    elemTab = `EOM_ELEM_US_TABLE;
    guardTab = `EOM_GUARD_X100US_TABLE;
    seedTab = `EOM_SEED_DELAY_MS_TABLE;
    toutTab = `EOM_TIMEOUT_X100MS_TABLE;
    wordTab = `EOM_MIN_WORDS_TABLE;
    wakeTab = `EOM_WAKE_MS_TABLE;
    dutyTab = `EOM_WAKE_PERMILLE_TABLE;
    sysA = sh[6];
    sysB = sh[7];
    // a request for the second set falls back to the first when dual is off
    useB = wantB && sysA[`EOM_SYSA_DUAL];
    ctl = useB ? sh[3] : sh[0];
    disc = useB ? sh[4] : sh[1];
    tim = useB ? sh[5] : sh[2];
    // blink and on-time of set B live in system byte A, those of set A in B
    perSet = useB ? sysA : sysB;
    o = '0;
    o.activeSetB = useB;
    o.modulation = eom_mod_t'(ctl[`EOM_CTL_MOD_LSB +: 2]);
    o.elementTimeUs = elemTab[tim[`EOM_TIM_ELEM_LSB +: 2]];
    o.guardTimeX100us = guardTab[tim[`EOM_TIM_GUARD_LSB +: 2]];
    o.headerElements = ctl[`EOM_CTL_HEADER] ? `EOM_HEADER_LONG_ELEM : `EOM_HEADER_SHORT_ELEM;
    o.serialBits = ctl[`EOM_CTL_LONG_SERIAL] ? `EOM_SERIAL_LONG_BITS : `EOM_SERIAL_SHORT_BITS;
    o.seedDelayMs = seedTab[tim[`EOM_TIM_SEED_DELAY_LSB +: 2]];
    o.seedProduction = tim[`EOM_TIM_SEED_MODE];
    o.seedLimited = tim[`EOM_TIM_SEED_LIMIT];
    o.pulseFrames = ctl[`EOM_CTL_PULSE];
    o.queueEnable = ctl[`EOM_CTL_QUEUE];
    o.discrimination = {ctl[`EOM_CTL_DISC_LSB +: 2], disc};
    o.counterBits = sysB[`EOM_SYSB_COUNTER_SEL] ? `EOM_COUNTER_LONG_BITS : `EOM_COUNTER_SHORT_BITS;
    o.minWords = wordTab[sysA[`EOM_SYSA_MIN_WORDS_LSB +: 2]];
    o.timeoutX100ms = toutTab[sysA[`EOM_SYSA_TIMEOUT_LSB +: 2]];
    o.wakePeriodMs = wakeTab[sysB[`EOM_SYSB_WAKE_LSB +: 2]];
    o.wakeDutyPermille = dutyTab[sysB[`EOM_SYSB_WAKE_LSB +: 2]];
    o.lowbattMv = sysB[`EOM_SYSB_LOWBATT_SEL] ? `EOM_LOWBATT_HIGH_MV : `EOM_LOWBATT_LOW_MV;
    o.lowbattLatch = sysB[`EOM_SYSB_LOWBATT_LATCH];
    o.blinkOnce = perSet[`EOM_SYS_BLINK];
    o.indicatorOnMs = perSet[`EOM_SYS_ON_TIME] ? `EOM_ON_TIME_LONG_MS : `EOM_ON_TIME_SHORT_MS;
    o.radioEnableOutput = sysA[`EOM_SYSA_RADIO_OUT];
    o.radioFsk = sysB[`EOM_SYSB_FSK];
    return o;
  endfunction : decodeOpts

  eom_link u_link (
    .progClk(progClk),
    .arst_n(arst_n),
    .progDataIn(progDataIn),
    .rdData(st_r.rdData),
    .linkReq(linkReq),
    .cmdTgl(cmdTgl),
    .wrTgl(wrTgl),
    .progDataOut(progDataOut),
    .progDataOe(progDataOe)
  );

  eom_sync3 #(
    .W(2)
  ) u_sync (
    .clk(ref_clk),
    .arst_n(arst_n),
    .d({wrTgl, cmdTgl}),
    .q(tglSync)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.optLoaded = 1'b0;
    st_nxt.tglSeen = tglSync;
    // linkReq is held by the link for the whole gap that follows each toggle
    if (tglSync[0] != st_r.tglSeen[0])
    begin
      st_nxt.rdData = st_r.mem[linkReq.addr];
    end
    if (tglSync[1] != st_r.tglSeen[1])
    begin
      st_nxt.mem[linkReq.addr] = linkReq.wrData;
    end
    unique case (st_r.fsm)
      EOM_IDLE:
      begin
        if (txStart)
        begin
          st_nxt.fsm = EOM_LOAD;
          st_nxt.loadIdx = 3'h0;
          st_nxt.selB = txSelectB;
          st_nxt.busy = 1'b1;
        end
      end
      EOM_LOAD:
      begin
        // every option byte is fetched fresh before the parameters change
        st_nxt.shadow[st_r.loadIdx] = st_r.mem[loadAddr(st_r.loadIdx)];
        st_nxt.loadIdx = st_r.loadIdx + 3'h1;
        if (st_r.loadIdx == 3'h7)
        begin
          st_nxt.fsm = EOM_DECODE;
        end
      end
      EOM_DECODE:
      begin
        st_nxt.opts = decodeOpts(st_r.shadow, st_r.selB);
        st_nxt.optValid = 1'b1;
        st_nxt.optLoaded = 1'b1;
        st_nxt.busy = 1'b0;
        st_nxt.fsm = EOM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign optBusy = st_r.busy;
  assign optValid = st_r.optValid;
  assign optLoaded = st_r.optLoaded;
  assign opts = st_r.opts;

  // helper views of the snapshot that the last decode used
  logic dualOn;
  logic [7:0] ctlSel;
  logic [7:0] timSel;
  logic [7:0] sysA;
  logic [7:0] sysB;
  assign sysA = st_r.shadow[6];
  assign sysB = st_r.shadow[7];
  assign dualOn = st_r.selB && sysA[`EOM_SYSA_DUAL];
  assign ctlSel = dualOn ? st_r.shadow[3] : st_r.shadow[0];
  assign timSel = dualOn ? st_r.shadow[5] : st_r.shadow[2];

  sequence s_start;
    txStart && (st_r.fsm == EOM_IDLE);
  endsequence

  sequence s_load_walk;
    (st_r.fsm == EOM_LOAD) [*8] ##1 (st_r.fsm == EOM_DECODE) ##1 optLoaded;
  endsequence

  property p_load_order;
    @(posedge ref_clk) disable iff (!arst_n)
    s_start |=> s_load_walk;
  endproperty
  a_load_order: assert property (p_load_order) else $error("option load did not take eight fetches");

  property p_set_select;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.activeSetB == dualOn);
  endproperty
  a_set_select: assert property (p_set_select) else $error("second set used without dual enable");

  property p_modulation;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.modulation == eom_mod_t'(ctlSel[3:2]));
  endproperty
  a_modulation: assert property (p_modulation) else $error("modulation format mismatch");

  property p_element_time;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.elementTimeUs == (10'd100 << timSel[5:4]));
  endproperty
  a_element_time: assert property (p_element_time) else $error("element time mismatch");

  property p_header_serial;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.headerElements == (ctlSel[4] ? 4'd10 : 4'd4))
      && (opts.serialBits == (ctlSel[5] ? 6'd32 : 6'd28));
  endproperty
  a_header_serial: assert property (p_header_serial) else $error("header or serial length mismatch");

  property p_discrimination;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.discrimination == {ctlSel[1:0], (dualOn ? st_r.shadow[4] : st_r.shadow[1])});
  endproperty
  a_discrimination: assert property (p_discrimination) else $error("discrimination mismatch");

  property p_counter_width;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.counterBits == (sysB[2] ? 5'd20 : 5'd16));
  endproperty
  a_counter_width: assert property (p_counter_width) else $error("counter width mismatch");

  property p_min_words;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.minWords == (4'd1 << sysA[1:0]));
  endproperty
  a_min_words: assert property (p_min_words) else $error("minimum word count mismatch");

  property p_timeout;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> ((opts.timeoutX100ms == 9'd0) == (sysA[5:4] == 2'b00));
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out disable mismatch");

  property p_lowbatt;
    @(posedge ref_clk) disable iff (!arst_n)
    optLoaded |-> (opts.lowbattMv == (sysB[4] ? 12'd3200 : 12'd2200)) && (opts.lowbattLatch == sysB[3]);
  endproperty
  a_lowbatt: assert property (p_lowbatt) else $error("low-voltage option mismatch");

  property p_flags_stable;
    @(posedge ref_clk) disable iff (!arst_n)
    (st_r.fsm == EOM_IDLE) && !txStart |=> $stable(opts);
  endproperty
  a_flags_stable: assert property (p_flags_stable) else $error("options changed without a load");

  property p_read_fetch;
    @(posedge ref_clk) disable iff (!arst_n)
    (tglSync[0] != st_r.tglSeen[0]) |=> (st_r.rdData == $past(st_r.mem[linkReq.addr]));
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("read byte not fetched");

  logic [7:0] gapCnt;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gapCnt <= '0;
    end
    else if (cmdTgl != st_r.tglSeen[0])
    begin
      gapCnt <= gapCnt + 8'h1;
    end
    else
    begin
      gapCnt <= '0;
    end
  end

  property p_fetch_in_gap;
    @(posedge ref_clk) disable iff (!arst_n)
    gapCnt < 8'(GAP_CYC);
  endproperty
  a_fetch_in_gap: assert property (p_fetch_in_gap) else $error("read fetch exceeds link gap");
endmodule : eom_option_decoder

/* bench/eom_prog_model.sv */
// programmer model: clocks command and data fields over the serial link
module eom_prog_model (
  output logic progClk,
  output logic drv,
  output logic drvOe,
  input wire logic dataWire
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    progClk = 1'b0;
    drv = 1'b0;
    drvOe = 1'b0;
  end

  // the link clock stands still between fields, so the device sees no stray edges
  task automatic field(input logic drive, input logic [7:0] val, output logic [7:0] got);
    for (int k = 7; k >= 0; k--)
    begin
      drvOe = drive;
      drv = val[k];
      #62.5 progClk = 1'b1;
      #62.5 got[k] = dataWire;
      progClk = 1'b0;
    end
    drvOe = 1'b0;
    #1000;
  endtask : field

  task automatic xfer(input logic isRd, input logic [5:0] addr, input logic [7:0] wr, output logic [7:0] rd);
    logic [7:0] unused;
    field(1'b1, {isRd, 1'b0, addr}, unused);
    field(!isRd, wr, rd);
  endtask : xfer
endmodule : eom_prog_model

/* bench/tb_encoder_option_memory_decode.sv */
// self-checking bench: programs option bytes over the link and checks decoded parameters
module tb_encoder_option_memory_decode;
  import eom_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [10:0] GUARD [4] = '{11'd0, 11'd64, 11'd512, 11'd1024};
  localparam logic [11:0] SDLY [4] = '{12'd0, 12'd800, 12'd1600, 12'd3200};
  localparam logic [8:0] TOUT [4] = '{9'd0, 9'd8, 9'd32, 9'd256};
  localparam logic [6:0] WMS [4] = '{7'd0, 7'd75, 7'd50, 7'd100};
  localparam logic [9:0] WDUTY [4] = '{10'd0, 10'd500, 10'd333, 10'd166};

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic txStart = 1'b0;
  logic txSelectB = 1'b0;
  logic floatLvl = 1'b0;
  logic progClk, drv, drvOe, dataWire, progDataOut, progDataOe, optBusy, optValid, optLoaded;
  eom_opt_t opts;
  eom_opt_t expQ[$];
  eom_opt_t expNow;
  int failures = 0;
  int checked = 0;
  logic [7:0] mem [8];
  logic [7:0] rd;
  logic [5:0] offs [8] = '{6'h1C, 6'h1D, 6'h3C, 6'h32, 6'h33, 6'h3E, 6'h3D, 6'h3F};
  int unsigned seed;

  always #5 ref_clk = ~ref_clk;
  // a released line keeps changing, so a stale bit can never pass for read data
  always @(posedge ref_clk) floatLvl <= ~floatLvl;
  assign dataWire = drvOe ? drv : (progDataOe ? progDataOut : floatLvl);

  eom_prog_model prog (.progClk(progClk), .drv(drv), .drvOe(drvOe), .dataWire(dataWire));
  eom_option_decoder uut (.ref_clk(ref_clk), .arst_n(arst_n), .progClk(progClk), .progDataIn(dataWire),
    .progDataOut(progDataOut), .progDataOe(progDataOe), .txStart(txStart), .txSelectB(txSelectB),
    .optBusy(optBusy), .optValid(optValid), .optLoaded(optLoaded), .opts(opts));

  function automatic eom_opt_t expOpt(input logic sel);
    eom_opt_t o;
    logic useB;
    logic [7:0] c, t, led;
    useB = sel & mem[6][2];
    c = useB ? mem[3] : mem[0];
    t = useB ? mem[5] : mem[2];
    led = useB ? mem[6] : mem[7];
    o.activeSetB = useB;
    o.modulation = eom_mod_t'(c[3:2]);
    o.elementTimeUs = 10'd100 << t[5:4];
    o.guardTimeX100us = GUARD[t[7:6]];
    o.headerElements = c[4] ? 4'd10 : 4'd4;
    o.serialBits = c[5] ? 6'd32 : 6'd28;
    o.seedDelayMs = SDLY[t[3:2]];
    o.seedProduction = t[1];
    o.seedLimited = t[0];
    o.pulseFrames = c[7];
    o.queueEnable = c[6];
    o.discrimination = {c[1:0], useB ? mem[4] : mem[1]};
    o.counterBits = mem[7][2] ? 5'd20 : 5'd16;
    o.minWords = 4'd1 << mem[6][1:0];
    o.timeoutX100ms = TOUT[mem[6][5:4]];
    o.wakePeriodMs = WMS[mem[7][1:0]];
    o.wakeDutyPermille = WDUTY[mem[7][1:0]];
    o.lowbattMv = mem[7][4] ? 12'd3200 : 12'd2200;
    o.lowbattLatch = mem[7][3];
    o.blinkOnce = led[6];
    o.indicatorOnMs = led[7] ? 7'd100 : 7'd50;
    o.radioEnableOutput = mem[6][3];
    o.radioFsk = mem[7][5];
    return o;
  endfunction : expOpt

  task automatic cmpOpt(input eom_opt_t e, input eom_opt_t g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmpOpt

  task automatic cmpByte(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmpByte

  task automatic summarize();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  always @(negedge ref_clk)
    if (optLoaded === 1'b1)
    begin
      cmpByte(8'h01, 8'(expQ.size() != 0));
      cmpByte(8'h02, {6'h00, optValid, optBusy});
      // all ones is never a legal decode, so a missing note cannot pass
      expNow = '1;
      if (expQ.size() != 0)
        expNow = expQ.pop_front();
      cmpOpt(expNow, opts);
    end

  initial
  begin
    #600000;
    failures++;
    summarize();
  end

  initial
  begin
    seed = $urandom(32'h2317);
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) arst_n = 1'b1;
    cmpOpt('0, opts);
    cmpByte(8'h00, {5'h00, progDataOe, optValid, optBusy});
    // first four rounds put every two-bit field through codes 0 to 3
    for (int i = 0; i < 8; i++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        mem[j] = i < 4 ? {4{i[1:0]}} : 8'($urandom);
        prog.xfer(1'b0, offs[j], mem[j], rd);
      end
      prog.xfer(1'b1, offs[i], 8'h00, rd);
      cmpByte(mem[i], rd);
      @(negedge ref_clk);
      txSelectB = 1'($urandom);
      txStart = 1'b1;
      expQ.push_back(expOpt(txSelectB));
      @(negedge ref_clk);
      // a second request held into the busy phase must be dropped
      txSelectB = ~txSelectB;
      cmpByte(8'h01, 8'(optBusy));
      @(negedge ref_clk);
      txStart = 1'b0;
      for (int w = 0; w < 40 && expQ.size() > 0; w++)
        @(negedge ref_clk);
      cmpByte(8'h00, 8'(expQ.size()));
      repeat (3) @(negedge ref_clk);
    end
    // a reset in mid-run must clear the stored bytes and the decoded set
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    cmpOpt('0, opts);
    cmpByte(8'h00, {5'h00, progDataOe, optValid, optBusy});
    prog.xfer(1'b1, offs[7], 8'h00, rd);
    cmpByte(8'h00, rd);
    summarize();
  end
endmodule : tb_encoder_option_memory_decode
